// *** src/clp_pkg.sv ***
package clp_pkg;
   // Transmit buffer state codes
   localparam logic [3:0] CODE_INACTIVE = 4'h8;
   localparam logic [3:0] CODE_DATA = 4'hC;
   localparam logic [3:0] CODE_ABORT = 4'h9;
   localparam logic [3:0] CODE_DONE = 4'h8;
   // Reset values
   localparam logic MODULE_DISABLE_BIT_RESET = 1'b1;
   localparam logic [3:0] CODE_RESET = 4'h8;
   // Pad level meaning
   localparam logic PAD_RECESSIVE = 1'b1;
   typedef enum logic [1:0] {
      CLP_RUN, CLP_FREEZE, CLP_DISABLED
   } clp_mode_t;
endpackage

// *** src/clp_tx_if.sv ***
interface clp_tx_if;
   import clp_pkg::*;
   logic code_wr;
   logic [3:0] code_wdata;
   logic deact_req;
   logic win_tx;
   logic [3:0] code;
   logic done_pulse;
   logic abort_pending;
   modport ctrl (output code_wr, code_wdata, deact_req, win_tx,
      input code, done_pulse, abort_pending);
   modport buf_side (input code_wr, code_wdata, deact_req, win_tx,
      output code, done_pulse, abort_pending);
endinterface

// *** src/clp_txbuf.sv ***
module clp_txbuf (
   input wire logic clk,
   input wire logic rst_b,
   clp_tx_if.buf_side tx
);
   import clp_pkg::*;
   logic [3:0] code_reg;
   logic abort_reg;
   logic deact_reg;
   logic done_reg;
   // Abort latches; deactivate takes effect on idle bus side
   wire is_abort = tx.code_wr && tx.code_wdata == CODE_ABORT;
   wire wr_ok = tx.code_wr && !abort_reg;
   // A deactivated frame may already sit in the engine and still leave
   wire send_done = tx.win_tx
      && (code_reg == CODE_DATA || abort_reg || deact_reg);
   ////////////////////////////////////////////////////////////////
   // Code field: locked after abort until a win completes
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         code_reg <= CODE_RESET;
         abort_reg <= 1'b0;
         deact_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (send_done && !deact_reg) begin
            code_reg <= CODE_DONE;
            done_reg <= 1'b1;
            abort_reg <= 1'b0;
         end else if (send_done) begin
            // Frame already loaded still leaves; no flag, code kept
            deact_reg <= 1'b0;
         end else if (wr_ok) begin
            code_reg <= tx.code_wdata;
            abort_reg <= is_abort;
            deact_reg <= tx.deact_req;
         end
      end
   end
   assign tx.code = code_reg;
   assign tx.done_pulse = done_reg;
   assign tx.abort_pending = abort_reg;

   AST_ABORT_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
      abort_reg && tx.code_wr && !send_done |=> $stable(code_reg))
      else $error("code changed while abort pending");
   AST_DEACT_NOFLAG: assert property (@(posedge clk) disable iff (!rst_b)
      deact_reg && send_done |=> !done_reg && $stable(code_reg))
      else $error("deactivated buffer flagged");
   COV_ABORT_WIN: cover property (@(posedge clk) disable iff (!rst_b)
      abort_reg ##[1:20] done_reg);
endmodule

// *** src/clp_ctrl.sv ***
module clp_ctrl (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic module_disable_bit,
   input wire logic freeze_req,
   input wire logic wake_irq_mask,
   input wire logic self_wake_enable,
   input wire logic rx_pad,
   input wire logic code_wr,
   input wire logic [3:0] code_wdata,
   input wire logic deact_req,
   input wire logic win_tx,
   output logic clk_stop_req,
   output logic low_power_ack,
   output logic freeze_ack,
   output logic wake_irq,
   output logic [3:0] buf_code,
   output logic buffer_done_flag,
   output logic abort_pending
);
   import clp_pkg::*;
   clp_mode_t mode_reg, mode_next;
   logic rx_prev_reg;
   logic module_disable_bit_prev_reg;
   logic stop_reg;
   logic lpack_reg;
   logic frzack_reg;
   logic wake_reg;
   logic [3:0] code_out_reg;
   logic done_out_reg;
   logic abort_out_reg;
   clp_tx_if tx ();

   ////////////////////////////////////////////////////////////////
   // Transmit buffer
   // Raw strobes go in; status comes back mirrored below
   assign tx.code_wr = code_wr;
   assign tx.code_wdata = code_wdata;
   assign tx.deact_req = deact_req;
   assign tx.win_tx = win_tx;
   clp_txbuf u_txbuf (
      .clk(clk),
      .rst_b(rst_b),
      .tx(tx)
   );

   ////////////////////////////////////////////////////////////////
   // Mode decode
   wire disable_now = module_disable_bit;
   wire module_disable_bit_fall = module_disable_bit_prev_reg && !module_disable_bit;
   // Falling edge of the pad, dominant is low
   wire rx_wake_edge = rx_prev_reg == PAD_RECESSIVE && rx_pad != PAD_RECESSIVE;
   // Disabled-mode test shared by the wake and request decodes
   function automatic logic is_off(input clp_mode_t m);
      return m == CLP_DISABLED;
   endfunction
   // Reproduces the known spurious wake on disable release
   wire spurious_wake = module_disable_bit_fall && wake_irq_mask && self_wake_enable
      && is_off(mode_reg);
   // Pad wake only counts while the engine clocks are stopped
   wire wake_event = (wake_irq_mask && rx_wake_edge
      && is_off(mode_reg)) || spurious_wake;

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         CLP_RUN: begin
            if (disable_now) mode_next = CLP_DISABLED;
            else if (freeze_req) mode_next = CLP_FREEZE;
         end
         CLP_FREEZE: begin
            if (disable_now) mode_next = CLP_DISABLED;
            else if (!freeze_req) mode_next = CLP_RUN;
         end
         CLP_DISABLED: begin
            if (!disable_now) mode_next = freeze_req ? CLP_FREEZE : CLP_RUN;
         end
         default: mode_next = CLP_RUN;
      endcase
   end

   // Next-state decodes feed the output flops directly
   wire dis_next = is_off(mode_next);
   wire frz_next = mode_next == CLP_FREEZE;

   ////////////////////////////////////////////////////////////////
   // Mode and input history; history resets to the idle pin levels
   // so that no false edge appears just after reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mode_reg <= CLP_DISABLED;
         rx_prev_reg <= PAD_RECESSIVE;
         module_disable_bit_prev_reg <= MODULE_DISABLE_BIT_RESET;
      end else begin
         mode_reg <= mode_next;
         rx_prev_reg <= rx_pad;
         module_disable_bit_prev_reg <= module_disable_bit;
      end
   end

   // Request and acks; the clock gate itself lives outside this block
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stop_reg <= MODULE_DISABLE_BIT_RESET;
         lpack_reg <= MODULE_DISABLE_BIT_RESET;
         frzack_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         stop_reg <= dis_next;
         lpack_reg <= dis_next;
         frzack_reg <= frz_next;
         wake_reg <= wake_event;
      end
   end

   // Mirror buffer status so outputs leave flip-flops
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         code_out_reg <= CODE_RESET;
         done_out_reg <= 1'b0;
         abort_out_reg <= 1'b0;
      end else begin
         code_out_reg <= tx.code;
         done_out_reg <= tx.done_pulse;
         abort_out_reg <= tx.abort_pending;
      end
   end

   assign clk_stop_req = stop_reg;
   assign low_power_ack = lpack_reg;
   assign freeze_ack = frzack_reg;
   assign wake_irq = wake_reg;
   assign buf_code = code_out_reg;
   assign buffer_done_flag = done_out_reg;
   assign abort_pending = abort_out_reg;

   ////////////////////////////////////////////////////////////////
   // Checks
   // Mode and clock request
   AST_DIS_REQ: assert property (@(posedge clk) disable iff (!rst_b)
      module_disable_bit |=> clk_stop_req)
      else $error("no clock stop request while disabled");
   AST_ENTER: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(module_disable_bit) |=> mode_reg == CLP_DISABLED)
      else $error("disable not entered");
   AST_FRZ_DIS: assert property (@(posedge clk) disable iff (!rst_b)
      freeze_ack && module_disable_bit
      |=> low_power_ack && !freeze_ack && clk_stop_req)
      else $error("freeze to disable handshake wrong");
   AST_LP_MATCH: assert property (@(posedge clk) disable iff (!rst_b)
      low_power_ack == clk_stop_req)
      else $error("ack and stop request differ");

   // Leaving disable withdraws the request so clocks come back
   AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(module_disable_bit) |=> !clk_stop_req && !low_power_ack)
      else $error("clock stop request kept after release");
   AST_RUN_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
      !module_disable_bit && !freeze_req
      |=> !clk_stop_req && !freeze_ack)
      else $error("run mode outputs wrong");
   AST_FRZ_ENTER: assert property (@(posedge clk) disable iff (!rst_b)
      !module_disable_bit && freeze_req |=> freeze_ack && !low_power_ack)
      else $error("freeze ack missing");
   AST_ACK_EXCL: assert property (@(posedge clk) disable iff (!rst_b)
      !(freeze_ack && low_power_ack))
      else $error("freeze and low-power ack together");
   AST_WAKE_CAUSE: assert property (@(posedge clk) disable iff (!rst_b)
      wake_irq |-> $past(rx_wake_edge) || $past(spurious_wake))
      else $error("wake without cause");
   AST_SPUR: assert property (@(posedge clk) disable iff (!rst_b)
      spurious_wake |=> wake_irq)
      else $error("release wake missing");
   AST_NOWAKE_MASK: assert property (@(posedge clk) disable iff (!rst_b)
      !wake_irq_mask |=> !wake_irq)
      else $error("wake while masked");

   // Wake path: disabled mode only; pad edge is the sole cause unless self wake is set
   AST_WAKE_MODE: assert property (@(posedge clk) disable iff (!rst_b)
      wake_irq |-> $past(mode_reg == CLP_DISABLED))
      else $error("wake outside disabled mode");
   AST_EDGE_WAKE: assert property (@(posedge clk) disable iff (!rst_b)
      wake_irq_mask && rx_wake_edge && mode_reg == CLP_DISABLED
      |=> wake_irq)
      else $error("pad edge wake missing");
   AST_PAD_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
      wake_irq && !$past(self_wake_enable) |-> $past(rx_wake_edge))
      else $error("wake without pad edge");
   AST_DONE_MIRROR: assert property (@(posedge clk) disable iff (!rst_b)
      tx.done_pulse |=> buffer_done_flag ##1 !buffer_done_flag)
      else $error("done flag not one pulse");

   // Buffer status mirror and abort release
   AST_CODE_MIRROR: assert property (@(posedge clk) disable iff (!rst_b)
      buf_code == $past(tx.code))
      else $error("buffer code mirror wrong");
   AST_ABORT_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(abort_pending) |-> buffer_done_flag)
      else $error("abort released without a win");
   COV_FRZ_DIS: cover property (@(posedge clk) disable iff (!rst_b)
      freeze_ack ##1 low_power_ack);
   COV_WAKE: cover property (@(posedge clk) disable iff (!rst_b) wake_irq);
   COV_SPUR: cover property (@(posedge clk) disable iff (!rst_b)
      spurious_wake ##1 wake_irq);
   COV_DONE: cover property (@(posedge clk) disable iff (!rst_b)
      buffer_done_flag);
endmodule

// *** testbench/clp_far_model.sv ***
//////////////////////////////////////////////////////////////////////
// Far side: bus pad and the outside clock gating unit
module clp_far_model (
   input wire logic clk_stop_req,
   input wire logic dom_req,
   output logic rx_pad,
   output logic eng_clk_on
);
   timeunit 1ns;
   timeprecision 1ps;
   import clp_pkg::*;
   // Pad rests recessive unless a node pulls it dominant
   assign rx_pad = dom_req ? ~PAD_RECESSIVE : PAD_RECESSIVE;
   // Gating decided here, never inside the controller
   assign eng_clk_on = ~clk_stop_req;
endmodule

// *** testbench/tb_top.sv ***
//////////////////////////////////////////////////////////////////////
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import clp_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, module_disable_bit = 1'b1;
   logic freeze_req = 1'b0, wake_irq_mask = 1'b0, self_wake_enable = 1'b0;
   logic code_wr = 1'b0, deact_req = 1'b0, win_tx = 1'b0, dom_req = 1'b0;
   logic [3:0] code_wdata = 4'h0;
   logic [3:0] buf_code;
   logic rx_pad, clk_stop_req, low_power_ack, freeze_ack, wake_irq;
   logic buffer_done_flag, abort_pending, eng_clk_on;
   int err_total = 0, tests_run = 0, cyc = 0, w, d;
   clp_ctrl i_clp_ctrl (.clk, .rst_b, .module_disable_bit, .freeze_req,
      .wake_irq_mask, .self_wake_enable, .rx_pad, .code_wr, .code_wdata,
      .deact_req, .win_tx, .clk_stop_req, .low_power_ack, .freeze_ack,
      .wake_irq, .buf_code, .buffer_done_flag, .abort_pending);
   clp_far_model i_clp_far_model (.clk_stop_req, .dom_req, .rx_pad,
      .eng_clk_on);
   // 50 MHz clock
   always #10 clk = ~clk;
   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         conclude();
      end
   end
   //////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [3:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Counts pulse cycles; window tolerates the answer latency
   task automatic watch(input int n);
      w = 0;
      d = 0;
      repeat (n) begin
         step(1);
         w += int'(wake_irq === 1'b1);
         d += int'(buffer_done_flag === 1'b1);
      end
   endtask
   task automatic wr(input logic [3:0] c, input logic dq);
      @(posedge clk);
      code_wr <= 1'b1;
      code_wdata <= c;
      deact_req <= dq;
      @(posedge clk);
      code_wr <= 1'b0;
      deact_req <= 1'b0;
      step(3);
   endtask
   task automatic send;
      @(posedge clk);
      win_tx <= 1'b1;
      @(posedge clk);
      win_tx <= 1'b0;
      watch(4);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      step(1);
      chk("stop req", clk_stop_req, 1'b1);
      chk("lp ack", low_power_ack, 1'b1);
      chk("code", buf_code, CODE_RESET);
      @(posedge clk);
      module_disable_bit <= 1'b0;
      freeze_req <= 1'b1;
      step(2);
      chk("clk on", eng_clk_on, 1'b1);
      chk("freeze_ack", freeze_ack, 1'b1);
      @(posedge clk);
      module_disable_bit <= 1'b1;
      step(1);
      chk("stop req", clk_stop_req, 1'b1);
      chk("lp ack", low_power_ack, 1'b1);
      chk("freeze_ack", freeze_ack, 1'b0);
      chk("clk on", eng_clk_on, 1'b0);
      $display("test modes done");
      @(posedge clk);
      module_disable_bit <= 1'b0;
      freeze_req <= 1'b0;
      wr(CODE_DATA, 1'b0);
      chk("code", buf_code, CODE_DATA);
      wr(CODE_ABORT, 1'b0);
      chk("abort", abort_pending, 1'b1);
      wr(CODE_DATA, 1'b0);
      chk("code", buf_code, CODE_ABORT);
      send();
      chk("done", 4'(d), 4'h1);
      chk("code", buf_code, CODE_DONE);
      wr(CODE_DATA, 1'b0);
      wr(CODE_INACTIVE, 1'b1);
      send();
      chk("done", 4'(d), 4'h0);
      chk("code", buf_code, CODE_INACTIVE);
      $display("test buffer done");
      @(posedge clk);
      module_disable_bit <= 1'b1;
      wake_irq_mask <= 1'b1;
      watch(5);
      chk("wake", 4'(w), 4'h0);
      @(posedge clk);
      dom_req <= 1'b1;
      watch(5);
      chk("wake", 4'(w), 4'h1);
      @(posedge clk);
      dom_req <= 1'b0;
      self_wake_enable <= 1'b1;
      watch(3);
      @(posedge clk);
      module_disable_bit <= 1'b0;
      watch(5);
      chk("wake", 4'(w), 4'h1);
      @(posedge clk);
      wake_irq_mask <= 1'b0;
      self_wake_enable <= 1'b0;
      module_disable_bit <= 1'b1;
      step(3);
      @(posedge clk);
      module_disable_bit <= 1'b0;
      watch(5);
      chk("wake", 4'(w), 4'h0);
      $display("test wake done");
      conclude();
   end
endmodule
